// >>> rtl/sac_regs.svh
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define SAC_ADDR_W            8
`define SAC_OFS_LINK_ENABLE   8'h00
`define SAC_OFS_OPTIONS       8'h18
`define SAC_OFS_SOFT_RESET    8'h1C
`define SAC_OFS_AUX_BUSY      8'h20
`define SAC_OFS_FAULT_TALLY   8'h24
`define SAC_OFS_TRANS_TALLY   8'h28
`define SAC_OFS_HOTPLUG_CMD   8'h2C
`define SAC_OFS_SYNC_HALF     8'h30
`define SAC_OFS_CMD_CODE      8'h34
`define SAC_OFS_TARGET_ADDR   8'h38
`define SAC_OFS_REQ_LENGTH    8'h3C

// ****************************************************************
// field positions
// ****************************************************************
`define SAC_BIT_LINK_ENABLE   0
`define SAC_BIT_FILTER_ON     0
`define SAC_BIT_LONG_WR_DEFER 1
`define SAC_BIT_I2C_AS_AUX    2
`define SAC_BIT_VIDEO_RST     0
`define SAC_BIT_AUX_RST       7
`define SAC_BIT_HOTPLUG_GO    0
`define SAC_HOTPLUG_DUR_HI    31
`define SAC_HOTPLUG_DUR_LO    16
`define SAC_I2C_ADDR_BITS     7

// ****************************************************************
// reset values and sizes
// ****************************************************************
`define SAC_RST_OPTIONS       3'h0
`define SAC_RST_DURATION      16'h0000
`define SAC_MSA_FIELDS        8
`define SAC_MSA_W             16
`define SAC_SYNC_MAX          10'h3FF

// ****************************************************************
// timing
// ****************************************************************
`define SAC_CLK_PERIOD_NS     5
`define SAC_US_NS             1000
`define SAC_CYC_PER_US        (`SAC_US_NS / `SAC_CLK_PERIOD_NS)
`define SAC_HOTPLUG_TYPICAL_US 750

// ****************************************************************
// bus answers
// ****************************************************************
`define SAC_RESP_OKAY         2'h0
`define SAC_RESP_DECERR       2'h3

`endif

// >>> rtl/sac_pkg.sv
`include "sac_regs.svh"

package sac_pkg;

    typedef struct packed {
        logic [3:0]  cmd;
        logic [19:0] addr;
        logic [3:0]  len;
        logic        addr_only;
        logic        i2c;
    } sac_aux_req_t;

    typedef logic [`SAC_MSA_W-1:0] sac_msa_word_t;
    typedef sac_msa_word_t [`SAC_MSA_FIELDS-1:0] sac_msa_t;

    typedef enum logic [0:0] {
        SAC_HPD_HIGH = 1'b0,
        SAC_HPD_LOW  = 1'b1
    } sac_hpd_state_t;

endpackage

// >>> rtl/sac_pair_filter.sv
`timescale 1ns/1ps
`default_nettype none
`include "sac_regs.svh"

module sac_pair_filter
    import sac_pkg::*;
#(
    parameter int W = `SAC_MSA_W
) (
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic         filter_on,
    input  wire logic         valid,
    input  wire logic [W-1:0] din,
    output var  logic [W-1:0] dout
);

    logic [W-1:0] last_seen;
    logic         seen;

    // ****************************************************************
    // accept on a repeat, or straight through when off
    // ****************************************************************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            last_seen <= '0;
            seen      <= 1'b0;
            dout      <= '0;
        end else if (valid) begin
            last_seen <= din;
            seen      <= 1'b1;
            if (!filter_on) begin
                dout <= din;
            end else if (seen && din == last_seen) begin
                dout <= din;
            end
        end
    end

endmodule

`default_nettype wire

// >>> rtl/sac_top.sv
// Functional notes
// - filter bit 0 clear: every attribute value passes straight through.
// - filter bit set: field updates only after two equal values in a row.
// - option bit 1: long I2C write transfers answered with DEFER.
// - option bit 2: I2C-level defer becomes an AUX DEFER reply.
// - soft reset bit 0 written 1 resets the video logic.
// - soft reset register reads back zero.
// - soft reset bit 7 written 1 resets the AUX logic.
// - busy bit 0 is 1 while an inbound AUX request is handled.
// - 8-bit error tally of AUX requests, cleared by a write to 0x28.
// - 8-bit request tally, any write to it clears it.
// - hot-plug command bit 0 written 1 with a nonzero length in bits 31:16 starts a low pulse on the line.
// - pulse length in microseconds from bits 31:16, default 0.
// - hot-plug command register reads back zero.
// - line held low for the programmed time, typically 750 us.
// - 10-bit count of clocks between sync edges of the last request.
// - 4-bit command of the last request captured.
// - 20-bit address of the last request captured.
// - I2C-over-AUX address keeps only its seven low bits.
// - link enable bit set enables receiver and raises hot-plug line.
// - length stored as bytes minus one, zero for address-only.
`timescale 1ns/1ps
`default_nettype none
`include "sac_regs.svh"

module sac_top
    import sac_pkg::*;
(
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    // host register bus
    input  wire logic [`SAC_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output var  logic                   s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output var  logic                   s_axi_wready,
    output var  logic [1:0]             s_axi_bresp,
    output var  logic                   s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [`SAC_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output var  logic                   s_axi_arready,
    output var  logic [31:0]            s_axi_rdata,
    output var  logic [1:0]             s_axi_rresp,
    output var  logic                   s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // aux engine side
    input  wire logic                   aux_req_start,
    input  wire logic                   aux_req_done,
    input  wire logic                   aux_req_error,
    input  wire sac_aux_req_t           aux_req,
    input  wire logic                   aux_sync_active,
    input  wire logic                   aux_rx_pin,
    input  wire logic                   i2c_long_write,
    input  wire logic                   i2c_defer,
    output var  logic                   aux_reply_defer,
    output var  logic                   aux_soft_rst,
    // main stream attributes
    input  wire logic                   msa_valid,
    input  wire sac_msa_t               msa_in,
    output var  sac_msa_t               msa_out,
    output var  logic                   video_soft_rst,
    // link
    output var  logic                   rx_enabled,
    output var  logic                   hpd_out
);

    // ****************************************************************
    // register bus
    // ****************************************************************
    logic                   wr_go;
    logic [`SAC_ADDR_W-1:0] wr_addr;
    logic                   wr_hit;
    logic [31:0]            next_rdata;
    logic                   rd_hit;

    assign wr_go   = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
    assign wr_addr = s_axi_awaddr;

    always_comb begin
        unique case (wr_addr)
            `SAC_OFS_LINK_ENABLE, `SAC_OFS_OPTIONS, `SAC_OFS_SOFT_RESET,
            `SAC_OFS_TRANS_TALLY, `SAC_OFS_HOTPLUG_CMD: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `SAC_RESP_OKAY;
        end else begin
            s_axi_awready <= wr_go;
            s_axi_wready  <= wr_go;
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `SAC_RESP_OKAY : `SAC_RESP_DECERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    logic                   link_enable;
    logic [2:0]             options;
    logic                   aux_busy;
    logic [7:0]             fault_tally;
    logic [7:0]             trans_tally;
    logic [9:0]             sync_half;
    logic [3:0]             cmd_code;
    logic [19:0]            target_addr;
    logic [3:0]             req_length;

    always_comb begin
        next_rdata = '0;
        rd_hit     = 1'b1;
        unique case (s_axi_araddr)
            `SAC_OFS_LINK_ENABLE: next_rdata[`SAC_BIT_LINK_ENABLE] = link_enable;
            `SAC_OFS_OPTIONS:     next_rdata[2:0] = options;
            `SAC_OFS_SOFT_RESET:  next_rdata = '0;
            `SAC_OFS_AUX_BUSY:    next_rdata[0] = aux_busy;
            `SAC_OFS_FAULT_TALLY: next_rdata[7:0] = fault_tally;
            `SAC_OFS_TRANS_TALLY: next_rdata[7:0] = trans_tally;
            `SAC_OFS_HOTPLUG_CMD: next_rdata = '0;
            `SAC_OFS_SYNC_HALF:   next_rdata[9:0] = sync_half;
            `SAC_OFS_CMD_CODE:    next_rdata[3:0] = cmd_code;
            `SAC_OFS_TARGET_ADDR: next_rdata[19:0] = target_addr;
            `SAC_OFS_REQ_LENGTH:  next_rdata[3:0] = req_length;
            default:              rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= `SAC_RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= next_rdata;
                s_axi_rresp  <= rd_hit ? `SAC_RESP_OKAY : `SAC_RESP_DECERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // control registers
    // ****************************************************************
    logic wr_link;
    logic wr_opts;
    logic wr_srst;
    logic wr_tally;
    logic wr_hpd;

    assign wr_link  = wr_go && wr_addr == `SAC_OFS_LINK_ENABLE && s_axi_wstrb[0];
    assign wr_opts  = wr_go && wr_addr == `SAC_OFS_OPTIONS && s_axi_wstrb[0];
    assign wr_srst  = wr_go && wr_addr == `SAC_OFS_SOFT_RESET && s_axi_wstrb[0];
    assign wr_tally = wr_go && wr_addr == `SAC_OFS_TRANS_TALLY;
    assign wr_hpd   = wr_go && wr_addr == `SAC_OFS_HOTPLUG_CMD && s_axi_wstrb[0];

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            link_enable <= 1'b0;
        end else if (wr_link) begin
            link_enable <= s_axi_wdata[`SAC_BIT_LINK_ENABLE];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            options <= `SAC_RST_OPTIONS;
        end else if (wr_opts) begin
            options <= s_axi_wdata[2:0];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            video_soft_rst <= 1'b0;
            aux_soft_rst   <= 1'b0;
        end else begin
            video_soft_rst <= wr_srst && s_axi_wdata[`SAC_BIT_VIDEO_RST];
            aux_soft_rst   <= wr_srst && s_axi_wdata[`SAC_BIT_AUX_RST];
        end
    end

    // ****************************************************************
    // defer policy
    // ****************************************************************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            aux_reply_defer <= 1'b0;
        end else begin
            aux_reply_defer <= (options[`SAC_BIT_LONG_WR_DEFER] && i2c_long_write)
                            || (options[`SAC_BIT_I2C_AS_AUX] && i2c_defer);
        end
    end

    // ****************************************************************
    // aux request capture
    // ****************************************************************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            aux_busy <= 1'b0;
        end else if (aux_req_start) begin
            aux_busy <= 1'b1;
        end else if (aux_req_done || aux_soft_rst) begin
            aux_busy <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cmd_code    <= '0;
            target_addr <= '0;
            req_length  <= '0;
        end else if (aux_req_done) begin
            cmd_code <= aux_req.cmd;
            if (aux_req.i2c) begin
                target_addr <= {13'h0000, aux_req.addr[`SAC_I2C_ADDR_BITS-1:0]};
            end else begin
                target_addr <= aux_req.addr;
            end
            req_length <= aux_req.addr_only ? 4'h0 : aux_req.len;
        end
    end

    // a clear and an event in one cycle leave a count of one
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            trans_tally <= '0;
        end else if (wr_tally) begin
            trans_tally <= {7'h00, aux_req_done};
        end else if (aux_req_done) begin
            trans_tally <= trans_tally + 8'h01;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fault_tally <= '0;
        end else if (wr_tally) begin
            fault_tally <= {7'h00, aux_req_error};
        end else if (aux_req_error) begin
            fault_tally <= fault_tally + 8'h01;
        end
    end

    // ****************************************************************
    // sync half period
    // ****************************************************************
    logic [2:0] rx_sync;
    logic       rx_level;
    logic       rx_edge;
    logic       edge_seen;
    logic [9:0] edge_cnt;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_sync  <= 3'h7;
            rx_level <= 1'b1;
        end else begin
            rx_sync <= {rx_sync[1:0], aux_rx_pin};
            if (rx_sync[1] == rx_sync[2]) begin
                rx_level <= rx_sync[2];
            end
        end
    end

    assign rx_edge = (rx_sync[1] == rx_sync[2]) && (rx_sync[2] != rx_level);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            edge_seen <= 1'b0;
            edge_cnt  <= '0;
            sync_half <= '0;
        end else if (!aux_sync_active) begin
            edge_seen <= 1'b0;
            edge_cnt  <= '0;
        end else if (rx_edge) begin
            if (edge_seen) begin
                sync_half <= edge_cnt;
            end
            edge_seen <= 1'b1;
            edge_cnt  <= 10'h001;
        end else if (edge_cnt != `SAC_SYNC_MAX) begin
            edge_cnt <= edge_cnt + 10'h001;
        end
    end

    // ****************************************************************
    // attribute filter
    // ****************************************************************
    for (genvar i = 0; i < `SAC_MSA_FIELDS; i++) begin : g_msa
        sac_pair_filter #(
            .W (`SAC_MSA_W)
        ) u_filter (
            .sys_clk   (sys_clk),
            .rst       (rst || video_soft_rst),
            .filter_on (options[`SAC_BIT_FILTER_ON]),
            .valid     (msa_valid),
            .din       (msa_in[i]),
            .dout      (msa_out[i])
        );
    end

    // ****************************************************************
    // hot-plug line
    // ****************************************************************
    sac_hpd_state_t hpd_state;
    logic [15:0]    us_left;
    logic [7:0]     us_div;
    logic           us_tick;

    assign us_tick = us_div == 8'(`SAC_CYC_PER_US - 1);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hpd_state <= SAC_HPD_HIGH;
            us_left   <= `SAC_RST_DURATION;
            us_div    <= '0;
        end else begin
            unique case (hpd_state)
                SAC_HPD_HIGH: begin
                    us_div <= '0;
                    if (wr_hpd && s_axi_wdata[`SAC_BIT_HOTPLUG_GO]
                        && s_axi_wdata[`SAC_HOTPLUG_DUR_HI:`SAC_HOTPLUG_DUR_LO] != 16'h0000) begin
                        us_left   <= s_axi_wdata[`SAC_HOTPLUG_DUR_HI:`SAC_HOTPLUG_DUR_LO];
                        hpd_state <= SAC_HPD_LOW;
                    end
                end
                SAC_HPD_LOW: begin
                    us_div <= us_tick ? 8'h00 : us_div + 8'h01;
                    if (us_tick) begin
                        us_left <= us_left - 16'h0001;
                        if (us_left == 16'h0001) begin
                            hpd_state <= SAC_HPD_HIGH;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_enabled <= 1'b0;
            hpd_out    <= 1'b0;
        end else begin
            rx_enabled <= link_enable;
            hpd_out    <= link_enable && hpd_state == SAC_HPD_HIGH
                       && !(wr_hpd && s_axi_wdata[`SAC_BIT_HOTPLUG_GO]
                            && s_axi_wdata[`SAC_HOTPLUG_DUR_HI:`SAC_HOTPLUG_DUR_LO] != 16'h0000);
        end
    end

endmodule

`default_nettype wire

// >>> testbench/sac_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "sac_regs.svh"
module sac_chk
    import sac_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_awready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        video_soft_rst,
    input wire logic        aux_soft_rst,
    input wire logic        rx_enabled,
    input wire logic        hpd_out
);
    logic        wr_sr;
    logic        hp_go;
    logic        in_pulse;
    logic [15:0] dur;
    logic [23:0] low_cnt;
    assign wr_sr = s_axi_awready && s_axi_awaddr == 8'h1C && s_axi_wstrb[0];
    assign hp_go = s_axi_awready && s_axi_awaddr == 8'h2C && s_axi_wstrb == 4'hF
                   && s_axi_wdata[0] && s_axi_wdata[31:16] != 16'h0000 && rx_enabled;
    // low time of the current hot-plug pulse
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            in_pulse <= 1'b0;
            dur      <= 16'h0000;
            low_cnt  <= 24'h000000;
        end else begin
            in_pulse <= (hp_go && !in_pulse) || (in_pulse && !hpd_out);
            low_cnt  <= hpd_out ? 24'h000000 : low_cnt + 24'h000001;
            if (hp_go && !in_pulse) begin
                dur <= s_axi_wdata[31:16];
            end
        end
    end
    default clocking dcb @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_video_rst; wr_sr && s_axi_wdata[0] |-> video_soft_rst; endproperty
    a_video_rst: assert property (p_video_rst) else $error("no video reset");
    property p_aux_rst; wr_sr && s_axi_wdata[7] |-> aux_soft_rst; endproperty
    a_aux_rst: assert property (p_aux_rst) else $error("no aux reset");
    property p_rst_pulse; video_soft_rst || aux_soft_rst |=> !(video_soft_rst || aux_soft_rst);
    endproperty
    a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too long");
    property p_sr_read; s_axi_arready && s_axi_araddr == 8'h1C |-> s_axi_rdata == 0; endproperty
    a_sr_read: assert property (p_sr_read) else $error("soft reset read not zero");
    property p_hp_read; s_axi_arready && s_axi_araddr == 8'h2C |-> s_axi_rdata == 0; endproperty
    a_hp_read: assert property (p_hp_read) else $error("hot-plug read not zero");
    property p_link_en; s_axi_awready && s_axi_awaddr == 8'h00 && s_axi_wstrb[0]
        |=> rx_enabled == $past(s_axi_wdata[0]); endproperty
    a_link_en: assert property (p_link_en) else $error("link enable not applied");
    property p_hp_start; hp_go && !in_pulse && $past(hpd_out) |-> !hpd_out; endproperty
    a_hp_start: assert property (p_hp_start) else $error("hot-plug pulse missing");
    property p_hp_len; in_pulse && hpd_out |-> low_cnt + 1 >= dur * `SAC_CYC_PER_US
        && low_cnt <= dur * `SAC_CYC_PER_US + 1; endproperty
    a_hp_len: assert property (p_hp_len) else $error("hot-plug pulse length");
endmodule
bind sac_top sac_chk chk_u (.*);
`default_nettype wire

// >>> testbench/sac_aux_model.sv
`timescale 1ns/1ps
`default_nettype none
module sac_aux_model
    import sac_pkg::*;
(
    input  wire logic         sys_clk,
    output var  logic         aux_req_start,
    output var  logic         aux_req_done,
    output var  logic         aux_req_error,
    output var  sac_aux_req_t aux_req,
    output var  logic         aux_sync_active,
    output var  logic         aux_rx_pin
);
    initial begin
        {aux_req_start, aux_req_done, aux_req_error, aux_sync_active, aux_rx_pin} = 5'h00;
        aux_req = '1;
    end
    // one request: sync edges every half cycles, fields only with done
    task automatic send(input sac_aux_req_t r, input logic err, input int half);
        @(negedge sys_clk);
        aux_req_start = 1'b1;
        aux_sync_active = 1'b1;
        @(negedge sys_clk);
        aux_req_start = 1'b0;
        repeat (4) begin
            repeat (half) @(negedge sys_clk);
            aux_rx_pin = !aux_rx_pin;
        end
        repeat (4) @(negedge sys_clk);
        aux_sync_active = 1'b0;
        {aux_req_done, aux_req_error} = {1'b1, err};
        aux_req = r;
        @(negedge sys_clk);
        {aux_req_done, aux_req_error} = 2'h0;
        aux_req = ~r;
    endtask
endmodule
`default_nettype wire

// >>> testbench/sink_aux_control_status_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sink_aux_control_status_regs_tb
    import sac_pkg::*;
;
    logic         sys_clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic         s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic         s_axi_rvalid, aux_req_start, aux_req_done, aux_req_error, aux_sync_active;
    logic         aux_rx_pin, i2c_long_write, i2c_defer, aux_reply_defer, aux_soft_rst;
    logic         msa_valid, video_soft_rst, rx_enabled, hpd_out;
    logic [7:0]   s_axi_awaddr, s_axi_araddr;
    logic [31:0]  s_axi_wdata, s_axi_rdata;
    logic [3:0]   s_axi_wstrb;
    logic [1:0]   s_axi_bresp, s_axi_rresp;
    sac_aux_req_t aux_req, r;
    sac_msa_t     msa_in, msa_out;
    int           err_total, tests_run, cyc;
    sac_top dut_u (.*);
    sac_aux_model pm_u (.*);
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail("timeout");
            results();
        end
    end
    task automatic fail(input string m);
        err_total++;
        $display("FAIL %0t %s", $time, m);
    endtask
    task automatic chk(input logic [127:0] g, input logic [127:0] e, input string m);
        tests_run++;
        if (g !== e) fail(m);
    endtask
    task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
        tests_run++;
        if (g !== e) fail("bus response");
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        int n;
        @(negedge sys_clk);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} = {a, d, 4'hF};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h7;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (s_axi_awready !== 1'b1 && n < 20);
        if (n == 20) fail("no write answer");
        chk_resp(s_axi_bresp, er);
        chk({s_axi_wready, s_axi_bvalid}, 2'h3, "write answer");
        @(negedge sys_clk);
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
        int n;
        @(negedge sys_clk);
        s_axi_araddr = a;
        {s_axi_arvalid, s_axi_rready} = 2'h3;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (s_axi_arready !== 1'b1 && n < 20);
        if (n == 20) fail("no read answer");
        chk_resp(s_axi_rresp, er);
        chk(s_axi_rvalid, 1'b1, "read valid");
        chk(s_axi_rdata, e, "read data");
        @(negedge sys_clk);
        {s_axi_arvalid, s_axi_rready} = 2'h0;
    endtask
    task automatic msa_put(input logic [15:0] v);
        @(negedge sys_clk);
        msa_in = {8{v}};
        msa_valid = 1'b1;
        @(negedge sys_clk);
        msa_valid = 1'b0;
        msa_in = ~msa_in;
        step(2);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        logic [7:0] ofs [9];
        int n;
        ofs = '{8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h38};
        rst = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {msa_valid, i2c_long_write, i2c_defer} = 3'h0;
        msa_in = '0;
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        foreach (ofs[i]) rd(ofs[i], 32'h0);
        rd(8'h40, 32'h0, 2'h3);
        wr(8'h40, 32'hFFFFFFFF, 2'h3);
        wr(8'h18, 32'h6);
        rd(8'h18, 32'h6);
        i2c_defer = 1'b1;
        step(2);
        chk(aux_reply_defer, 1'b1, "i2c defer");
        {i2c_defer, i2c_long_write} = 2'h1;
        step(2);
        chk(aux_reply_defer, 1'b1, "long write defer");
        wr(8'h18, 32'h4);
        step(2);
        chk(aux_reply_defer, 1'b0, "defer off");
        msa_put(16'h1234);
        chk(msa_out, {8{16'h1234}}, "msa pass");
        wr(8'h18, 32'h1);
        msa_put(16'h5678);
        chk(msa_out, {8{16'h1234}}, "msa single");
        msa_put(16'h5678);
        chk(msa_out, {8{16'h5678}}, "msa pair");
        wr(8'h1C, 32'h81);
        rd(8'h1C, 32'h0);
        chk(msa_out, 128'h0, "video reset");
        r = '{4'h9, 20'hABCDE, 4'h3, 1'b0, 1'b0};
        fork
            pm_u.send(r, 1'b0, 6);
            begin
                step(8);
                rd(8'h20, 32'h1);
            end
        join
        rd(8'h20, 32'h0);
        rd(8'h34, 32'h9);
        rd(8'h38, 32'hABCDE);
        rd(8'h30, 32'h6);
        rd(8'h3C, 32'h3);
        rd(8'h28, 32'h1);
        {r.addr_only, r.i2c} = 2'h3;
        pm_u.send(r, 1'b1, 6);
        rd(8'h38, 32'h5E);
        rd(8'h3C, 32'h0);
        rd(8'h24, 32'h1);
        wr(8'h28, 32'h0);
        rd(8'h24, 32'h0);
        rd(8'h28, 32'h0);
        repeat (257) pm_u.send(r, 1'b1, 2);
        rd(8'h24, 32'h1);
        rd(8'h28, 32'h1);
        fork
            pm_u.send(r, 1'b0, 6);
            begin
                step(6);
                wr(8'h1C, 32'h80);
                rd(8'h20, 32'h0);
            end
        join
        wr(8'h00, 32'h1);
        step(1);
        chk({rx_enabled, hpd_out}, 2'h3, "link enable");
        wr(8'h2C, 32'h1);
        step(20);
        chk(hpd_out, 1'b1, "zero length");
        wr(8'h2C, 32'h00010001);
        chk(hpd_out, 1'b0, "pulse start");
        rd(8'h2C, 32'h0);
        n = 4;
        while (hpd_out === 1'b0 && n < 1000) begin
            @(negedge sys_clk);
            n++;
        end
        chk(n >= 199 && n <= 201, 1'b1, "pulse length");
        results();
    end
endmodule
`default_nettype wire
